// ==== rtl/remote_serial_interface_select.v ====
`timescale 1ns/1ps
`default_nettype none
`include "remote_serial_defs.vh"
module remote_serial_interface_select #(
   parameter [31:0] HOLD_CYCLES = `HOLD_CYCLES
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        rs232Rx,
   output reg         rs232Tx,
   input  wire        usbVirtualSerialPortRx,
   output reg         usbVirtualSerialPortTx,
   input  wire        usbConnected,
   input  wire        unlockSoftkeyN,
   output reg         keyLock,
   output reg  [1:0]  indicatorSel,
   output reg         indicatorBright
);
   localparam RX_IDLE = 2'd0, RX_START = 2'd1, RX_DATA = 2'd2, RX_STOP = 2'd3;
   localparam [8*`ID_LEN-1:0] ID_TEXT = `ID_TEXT;

   function [9:0] baudDiv;
      input [2:0] sel;
      integer div;
      begin
         case (sel)
            3'd0:    div = `CLK_HZ / (`BAUD_0 * `OVERSAMPLE);
            3'd1:    div = `CLK_HZ / (`BAUD_1 * `OVERSAMPLE);
            3'd2:    div = `CLK_HZ / (`BAUD_2 * `OVERSAMPLE);
            3'd3:    div = `CLK_HZ / (`BAUD_3 * `OVERSAMPLE);
            default: div = `CLK_HZ / (`BAUD_4 * `OVERSAMPLE);
         endcase
         // Every divider of the set fits ten bits
         baudDiv = div[9:0];
      end
   endfunction

   reg  [31:0] ctrl_q;
   reg  [1:0]  rsSync_q;
   reg  [1:0]  usbSync_q;
   reg  [1:0]  vbusSync_q;
   reg  [1:0]  keySync_q;
   reg         vbusPrev_q;
   reg  [9:0]  tickCnt_q;
   reg         tick_q;
   reg  [1:0]  rxState_q;
   reg  [3:0]  rxPhase_q;
   reg  [2:0]  rxBit_q;
   reg  [7:0]  rxShift_q;
   reg         rxPrev_q;
   reg  [7:0]  rxData_q;
   reg         rxValid_q;
   reg         frameErr_q;
   reg         rxDone_q;
   reg  [39:0] lineBuf_q;
   reg         lineAny_q;
   reg         remote_q;
   reg         bright_q;
   reg  [9:0]  txShift_q;
   reg  [3:0]  txBits_q;
   reg  [3:0]  txPhase_q;
   reg         idBusy_q;
   reg  [5:0]  idIdx_q;
   reg  [31:0] holdCnt_q;

   wire [1:0] ifSel   = ctrl_q[`CTRL_IF_MSB:`CTRL_IF_LSB];
   wire       serialIf = (ifSel == `IF_RS232) || (ifSel == `IF_USB);
   // Only the selected line reaches the receiver; others read as idle
   wire       rxLine  = (ifSel == `IF_RS232) ? rsSync_q[1] :
                        (ifSel == `IF_USB)   ? usbSync_q[1] : 1'b1;
   wire       apbAcc  = psel && penable && pready;
   wire       apbWr   = apbAcc && pwrite;
   wire       apbRd   = apbAcc && !pwrite;
   wire       mapped  = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                        (paddr == `REG_TXDATA) || (paddr == `REG_RXDATA);
   wire       txBusy  = (txBits_q != 4'd0);
   wire       swTx    = apbWr && (paddr == `REG_TXDATA) && !txBusy && !idBusy_q;
   wire       idTx    = idBusy_q && !txBusy;
   wire [7:0] idChar  = ID_TEXT[8*(`ID_LEN-1-idIdx_q) +: 8];
   wire       isTerm  = (rxData_q == `CH_LF) || (rxData_q == `CH_CR);
   wire       cmdLocal = rxDone_q && isTerm && (lineBuf_q == `CMD_LOCAL);
   wire       cmdIdn   = rxDone_q && isTerm && (lineBuf_q == `CMD_IDN);
   wire       cmdOther = rxDone_q && isTerm && lineAny_q && !cmdLocal;
   wire       holdDone = (holdCnt_q >= HOLD_CYCLES - 32'd1);
   wire       usbDrop  = (ifSel == `IF_USB) && vbusPrev_q && !vbusSync_q[1];
   wire       ifChange = apbWr && (paddr == `REG_CTRL) &&
                         (pwdata[`CTRL_IF_MSB:`CTRL_IF_LSB] != ifSel);

   // Synchronisers; stage one is read only by stage two
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsSync_q   <= 2'h3;
         usbSync_q  <= 2'h3;
         vbusSync_q <= 2'h0;
         keySync_q  <= 2'h3;
         vbusPrev_q <= 1'b0;
      end else begin
         rsSync_q   <= {rsSync_q[0], rs232Rx};
         usbSync_q  <= {usbSync_q[0], usbVirtualSerialPortRx};
         vbusSync_q <= {vbusSync_q[0], usbConnected};
         keySync_q  <= {keySync_q[0], unlockSoftkeyN};
         vbusPrev_q <= vbusSync_q[1];
      end
   end

   // APB slave: one wait state, registered answer
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         ctrl_q  <= `CTRL_RESET;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready) begin
            case (paddr)
               `REG_CTRL:   prdata <= ctrl_q;
               `REG_STATUS: prdata <= {26'h0, vbusSync_q[1], txBusy || idBusy_q,
                                       frameErr_q, rxValid_q, bright_q, remote_q};
               `REG_RXDATA: prdata <= {24'h0, rxData_q};
               default:     prdata <= 32'h00000000;
            endcase
         end
         if (apbWr && paddr == `REG_CTRL)
            ctrl_q <= {27'h0, pwdata[`CTRL_BAUD_MSB:0]};
      end
   end

   // 16x oversample tick at the chosen rate
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt_q <= 10'h000;
         tick_q    <= 1'b0;
      end else if (tickCnt_q >= baudDiv(ctrl_q[`CTRL_BAUD_MSB:`CTRL_BAUD_LSB]) - 10'h001) begin
         tickCnt_q <= 10'h000;
         tick_q    <= 1'b1;
      end else begin
         tickCnt_q <= tickCnt_q + 10'h001;
         tick_q    <= 1'b0;
      end
   end

   // Receiver, 8N1
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxState_q  <= RX_IDLE;
         rxPhase_q  <= 4'h0;
         rxBit_q    <= 3'h0;
         rxShift_q  <= 8'h00;
         rxPrev_q   <= 1'b1;
         rxData_q   <= 8'h00;
         rxValid_q  <= 1'b0;
         frameErr_q <= 1'b0;
         rxDone_q   <= 1'b0;
      end else begin
         rxDone_q <= 1'b0;
         rxPrev_q <= rxLine;
         // Hardware set wins over a same-cycle software clear
         if (apbRd && paddr == `REG_RXDATA)
            rxValid_q <= 1'b0;
         if (apbWr && paddr == `REG_STATUS && pwdata[`ST_FRAMEERR])
            frameErr_q <= 1'b0;
         case (rxState_q)
            RX_IDLE: begin
               if (rxPrev_q && !rxLine) begin
                  rxState_q <= RX_START;
                  rxPhase_q <= 4'h0;
               end
            end
            RX_START: begin
               if (tick_q) begin
                  rxPhase_q <= rxPhase_q + 4'h1;
                  if (rxPhase_q == 4'h7) begin
                     rxPhase_q <= 4'h0;
                     rxBit_q   <= 3'h0;
                     // A glitch shorter than half a bit is not a start
                     rxState_q <= rxLine ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (tick_q) begin
                  rxPhase_q <= rxPhase_q + 4'h1;
                  if (rxPhase_q == 4'hF) begin
                     rxShift_q <= {rxLine, rxShift_q[7:1]};
                     rxBit_q   <= rxBit_q + 3'h1;
                     if (rxBit_q == 3'h7)
                        rxState_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (tick_q) begin
                  rxPhase_q <= rxPhase_q + 4'h1;
                  if (rxPhase_q == 4'hF) begin
                     rxState_q <= RX_IDLE;
                     if (!rxLine) begin
                        frameErr_q <= 1'b1;
                     end else begin
                        rxData_q  <= rxShift_q;
                        rxValid_q <= 1'b1;
                        rxDone_q  <= 1'b1;
                     end
                  end
               end
            end
            default: rxState_q <= RX_IDLE;
         endcase
      end
   end

   // Line parser and remote/local state
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lineBuf_q <= 40'h0;
         lineAny_q <= 1'b0;
         remote_q  <= 1'b0;
         bright_q  <= 1'b0;
         holdCnt_q <= 32'h00000000;
      end else begin
         if (rxDone_q) begin
            if (isTerm) begin
               lineBuf_q <= 40'h0;
               lineAny_q <= 1'b0;
            end else begin
               lineBuf_q <= {lineBuf_q[31:0], rxData_q};
               lineAny_q <= 1'b1;
            end
         end
         holdCnt_q <= keySync_q[1] ? 32'h00000000 :
                      (holdDone ? holdCnt_q : holdCnt_q + 32'h00000001);
         if (cmdOther) begin
            remote_q <= 1'b1;
            bright_q <= 1'b1;
         end
         if (cmdLocal) begin
            remote_q <= 1'b0;
            bright_q <= 1'b1;
         end
         // Key and cable release override any command in the same cycle
         if (holdDone && !keySync_q[1])
            remote_q <= 1'b0;
         if (usbDrop)
            remote_q <= 1'b0;
         if (ifChange) begin
            remote_q <= 1'b0;
            bright_q <= 1'b0;
         end
      end
   end

   // Transmitter: identification reply has priority over software bytes
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txShift_q <= 10'h3FF;
         txBits_q  <= 4'h0;
         txPhase_q <= 4'h0;
         idBusy_q  <= 1'b0;
         idIdx_q   <= 6'h00;
      end else begin
         if (cmdIdn) begin
            idBusy_q <= 1'b1;
            idIdx_q  <= 6'h00;
         end else if (idTx) begin
            txShift_q <= {1'b1, idChar, 1'b0};
            txBits_q  <= 4'hA;
            txPhase_q <= 4'h0;
            idIdx_q   <= idIdx_q + 6'h01;
            if ({26'h0, idIdx_q} == `ID_LEN - 1)
               idBusy_q <= 1'b0;
         end else if (swTx) begin
            txShift_q <= {1'b1, pwdata[7:0], 1'b0};
            txBits_q  <= 4'hA;
            txPhase_q <= 4'h0;
         end else if (txBusy && tick_q) begin
            txPhase_q <= txPhase_q + 4'h1;
            if (txPhase_q == 4'hF) begin
               txShift_q <= {1'b1, txShift_q[9:1]};
               txBits_q  <= txBits_q - 4'h1;
            end
         end
      end
   end

   // Pins and indicators
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rs232Tx                <= 1'b1;
         usbVirtualSerialPortTx <= 1'b1;
         keyLock                <= 1'b0;
         indicatorSel           <= `IF_RS232;
         indicatorBright        <= 1'b0;
      end else begin
         rs232Tx                <= (ifSel == `IF_RS232) ? txShift_q[0] : 1'b1;
         usbVirtualSerialPortTx <= (ifSel == `IF_USB) ? txShift_q[0] : 1'b1;
         keyLock                <= remote_q && serialIf;
         indicatorSel           <= ifSel;
         indicatorBright        <= bright_q;
      end
   end
endmodule // remote_serial_interface_select
`default_nettype wire

// ==== rtl/remote_serial_defs.vh ====
`ifndef REMOTE_SERIAL_DEFS_VH
`define REMOTE_SERIAL_DEFS_VH
// APB register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_TXDATA    8'h08
`define REG_RXDATA    8'h0C
// CTRL fields
`define CTRL_IF_LSB   0
`define CTRL_IF_MSB   1
`define CTRL_BAUD_LSB 2
`define CTRL_BAUD_MSB 4
`define CTRL_RESET    32'h00000010
// STATUS bit positions
`define ST_REMOTE     0
`define ST_BRIGHT     1
`define ST_RXVALID    2
`define ST_FRAMEERR   3
`define ST_TXBUSY     4
`define ST_USBCONN    5
// Interface selection codes
`define IF_RS232      2'h0
`define IF_USB        2'h1
`define IF_GPIB       2'h2
`define IF_LAN        2'h3
// Timing
`define CLK_HZ        50000000
`define OVERSAMPLE    16
`define BAUD_0        9600
`define BAUD_1        19200
`define BAUD_2        38400
`define BAUD_3        57600
`define BAUD_4        115200
`define HOLD_MS       1000
`define HOLD_CYCLES   ((`CLK_HZ / 1000) * `HOLD_MS)
// Identification reply, four comma-separated fields; text is arbitrary
`define ID_TEXT       "MAKER,SUPPLY1,SN:00000000,V1.00\n"
`define ID_LEN        32
// Characters seen by the line parser
`define CH_LF         8'h0A
`define CH_CR         8'h0D
`define CMD_LOCAL     40'h4C4F43414C
`define CMD_IDN       40'h2A49444E3F
`endif

// ==== bench/remote_serial_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module remote_serial_chk #(parameter [31:0] HOLD_CYCLES = 32'h14) (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       rs232Tx,
   input wire logic       usbVirtualSerialPortTx,
   input wire logic       usbConnected,
   input wire logic       unlockSoftkeyN,
   input wire logic       keyLock,
   input wire logic [1:0] indicatorSel,
   input wire logic       indicatorBright
);
   logic [31:0] holdCnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Saturates so the release check keeps holding while the key stays down
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         holdCnt_q <= 32'h0;
      else if (unlockSoftkeyN)
         holdCnt_q <= 32'h0;
      else if (holdCnt_q != HOLD_CYCLES + 32'h8)
         holdCnt_q <= holdCnt_q + 32'h1;
   end
   property p_rsQuiet; (indicatorSel != 2'h0) |-> rs232Tx; endproperty
   a_rsQuiet: assert property (p_rsQuiet)
      else $error("rs232 line busy while unselected");
   property p_usbQuiet; (indicatorSel != 2'h1) |-> usbVirtualSerialPortTx; endproperty
   a_usbQuiet: assert property (p_usbQuiet)
      else $error("usb line busy while unselected");
   property p_lockSerial; keyLock |-> !indicatorSel[1]; endproperty
   a_lockSerial: assert property (p_lockSerial)
      else $error("keys locked on a non-serial interface");
   property p_lockBright; keyLock |-> indicatorBright; endproperty
   a_lockBright: assert property (p_lockBright)
      else $error("remote state with dim indicator");
   property p_answer; (psel && $rose(penable)) |=> pready; endproperty
   a_answer: assert property (p_answer)
      else $error("no answer in second access cycle");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   property p_errReady; pslverr |-> pready && psel && penable; endproperty
   a_errReady: assert property (p_errReady)
      else $error("error outside an access");
   property p_unlock; (holdCnt_q == HOLD_CYCLES + 32'h8) |-> !keyLock; endproperty
   a_unlock: assert property (p_unlock)
      else $error("long unlock press left keys locked");
   property p_usbDrop; (!usbConnected && indicatorSel == 2'h1) [*4] |=> !keyLock; endproperty
   a_usbDrop: assert property (p_usbDrop)
      else $error("cable gone but keys locked");
endmodule // remote_serial_chk
bind remote_serial_interface_select remote_serial_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .rs232Tx(rs232Tx), .usbVirtualSerialPortTx(usbVirtualSerialPortTx),
   .usbConnected(usbConnected), .unlockSoftkeyN(unlockSoftkeyN), .keyLock(keyLock),
   .indicatorSel(indicatorSel), .indicatorBright(indicatorBright));
`default_nettype wire

// ==== bench/host_terminal_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_terminal_model (
   input wire logic  clk,
   input wire logic  rxLine,
   output var logic  txLine
);
   int         bitClks = 432;
   int         rxCount = 0;
   logic [7:0] lastByte;
   logic [7:0] shiftIn;
   initial txLine = 1'b1; // Line idles high, crossed to the device input
   task automatic sendByte(input logic [7:0] b, input logic stopBit);
      logic [9:0] frame;
      frame = {stopBit, b, 1'b0}; // Start low, LSB first, one stop, no parity
      for (int i = 0; i < 10; i++) begin
         txLine <= frame[i];
         repeat (bitClks) @(posedge clk);
      end
      // A broken stop bit must not leave the line parked low
      if (!stopBit) begin
         txLine <= 1'b1;
         repeat (bitClks) @(posedge clk);
      end
   endtask
   task automatic sendText(input string s);
      foreach (s[i]) sendByte(s[i], 1'b1);
   endtask
   initial begin
      forever begin
         @(negedge rxLine);
         repeat (bitClks / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bitClks) @(posedge clk);
            shiftIn[i] = rxLine;
         end
         repeat (bitClks) @(posedge clk);
         lastByte = shiftIn;
         rxCount++;
      end
   end
endmodule // host_terminal_model
`default_nettype wire

// ==== bench/test_remote_serial_interface_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "remote_serial_defs.vh"
module test_remote_serial_interface_select;
   logic        clk, sys_rst, psel, penable, pwrite, usbConnected, unlockSoftkeyN, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   wire logic   pready, pslverr, rs232Rx, rs232Tx, usbRx, usbTx, keyLock, indicatorBright;
   wire logic [31:0] prdata;
   wire logic [1:0]  indicatorSel;
   int          failures = 0;
   int          samplesChecked = 0;
   string       idText = `ID_TEXT;
   remote_serial_interface_select #(.HOLD_CYCLES(32'h14)) dut (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rs232Rx(rs232Rx),
      .rs232Tx(rs232Tx), .usbVirtualSerialPortRx(usbRx), .usbVirtualSerialPortTx(usbTx),
      .usbConnected(usbConnected), .unlockSoftkeyN(unlockSoftkeyN), .keyLock(keyLock),
      .indicatorSel(indicatorSel), .indicatorBright(indicatorBright));
   host_terminal_model rsHost (.clk(clk), .rxLine(rs232Tx), .txLine(rs232Rx));
   host_terminal_model usbHost (.clk(clk), .rxLine(usbTx), .txLine(usbRx));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      check("answer cycles", 32'h2, n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic lockIs(input logic l, input logic b);
      repeat (30) @(posedge clk);
      check("keyLock", {31'h0, l}, {31'h0, keyLock});
      check("bright", {31'h0, b}, {31'h0, indicatorBright});
   endtask
   task automatic testResetApb;
      apb(1'b0, `REG_CTRL, 32'h0);
      check("ctrl", `CTRL_RESET, rd);
      check("lines", 32'h3, {30'h0, rs232Tx, usbTx});
      check("sel", 32'h0, {30'h0, indicatorSel});
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", 32'h1, {31'h0, err});
      $display("reset and bus test done");
   endtask
   task automatic testRemoteLocal;
      rsHost.sendText("A\r");
      lockIs(1'b1, 1'b1);
      rsHost.sendText("LOCAL\r");
      lockIs(1'b0, 1'b1);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("rxValid", 32'h1, {31'h0, rd[`ST_RXVALID]});
      apb(1'b0, `REG_RXDATA, 32'h0);
      check("rxData", {24'h0, `CH_CR}, rd);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("rxValid clr", 32'h0, {31'h0, rd[`ST_RXVALID]});
      $display("remote and local test done");
   endtask
   task automatic testFrame;
      // Second byte arrives while the first is on the line and must be dropped
      apb(1'b1, `REG_TXDATA, 32'hA5);
      apb(1'b1, `REG_TXDATA, 32'h3C);
      rsHost.sendByte(8'h55, 1'b0);
      check("txCount", 32'h1, rsHost.rxCount);
      check("txByte", 32'hA5, {24'h0, rsHost.lastByte});
      apb(1'b0, `REG_STATUS, 32'h0);
      check("frameErr", 32'h1, {31'h0, rd[`ST_FRAMEERR]});
      check("status", (32'h1 << `ST_USBCONN) | (32'h1 << `ST_FRAMEERR) |
            (32'h1 << `ST_BRIGHT), rd);
      apb(1'b1, `REG_STATUS, 32'h8);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("frameErr clr", 32'h0, {31'h0, rd[`ST_FRAMEERR]});
      $display("framing test done");
   endtask
   task automatic testBaudUnlock;
      apb(1'b1, `REG_CTRL, 32'hC);
      rsHost.bitClks = `CLK_HZ / (`BAUD_3 * `OVERSAMPLE) * `OVERSAMPLE;
      rsHost.sendText("Q\r");
      lockIs(1'b1, 1'b1);
      unlockSoftkeyN <= 1'b0;
      lockIs(1'b0, 1'b1);
      unlockSoftkeyN <= 1'b1;
      rsHost.bitClks = `CLK_HZ / (`BAUD_4 * `OVERSAMPLE) * `OVERSAMPLE;
      $display("baud and unlock test done");
   endtask
   task automatic testUsb;
      int n = 0;
      apb(1'b1, `REG_CTRL, 32'h11);
      lockIs(1'b0, 1'b0);
      check("sel", 32'h1, {30'h0, indicatorSel});
      // The ignored line finishes last, so obeying it would show
      fork
         usbHost.sendText("*IDN?\r");
         begin
            repeat (600) @(posedge clk);
            rsHost.sendText("LOCAL\r");
         end
      join
      lockIs(1'b1, 1'b1);
      while (usbHost.rxCount < 1 && n < 6000) begin
         @(posedge clk);
         n++;
      end
      check("reply", {24'h0, idText[0]}, {24'h0, usbHost.lastByte});
      usbConnected <= 1'b0;
      lockIs(1'b0, 1'b1);
      $display("usb test done");
   endtask
   task automatic testMidReset;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, `REG_CTRL, 32'h0);
      check("ctrl again", `CTRL_RESET, rd);
      check("sel again", 32'h0, {30'h0, indicatorSel});
      lockIs(1'b0, 1'b0);
      $display("mid-run reset test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge clk);
      failures++;
      $display("wrong value watchdog expected end seen hang");
      give_verdict;
   end
   initial begin
      {sys_rst, usbConnected, unlockSoftkeyN} = 3'h7;
      {psel, penable, pwrite, paddr, pwdata} = 43'h0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      testResetApb;
      testRemoteLocal;
      testFrame;
      testBaudUnlock;
      testUsb;
      testMidReset;
      give_verdict;
   end
endmodule // test_remote_serial_interface_select
`default_nettype wire
